// ===== abx_pkg.sv
/*
  Shared constants and carriers for the add and bit-clear execution block.
  Assumes a 14-bit instruction word and an 8-bit datapath.
*/
`default_nettype none
// Contract
// - Add-literal adds literal to accumulator, updates carry, nibble carry, zero, one cycle.
// - AND-literal ANDs literal into accumulator, updates zero only, one cycle.
// - Add-register adds accumulator to register, updates carry, nibble carry, zero.
// - Destination bit 0 writes accumulator; 1 writes register, accumulator unchanged.
// - AND-register ANDs accumulator with register, routed by destination, zero only.
// - Bit-clear zeroes selected register bit, no flags touched, one cycle.
package abx_pkg;
  // ------------------------------------------------------------
  // Encoding fields
  // ------------------------------------------------------------
  localparam int          ABX_IW          = 14;
  localparam int          ABX_DW          = 8;
  localparam int          ABX_AW          = 7;
  localparam logic [4:0]  ABX_OP_ADDLIT   = 5'h1F;   // 11 111x
  localparam logic [5:0]  ABX_OP_ANDLIT   = 6'h39;   // 11 1001
  localparam logic [5:0]  ABX_OP_ADDREG   = 6'h07;   // 00 0111
  localparam logic [5:0]  ABX_OP_ANDREG   = 6'h05;   // 00 0101
  localparam logic [3:0]  ABX_OP_BITCLR   = 4'h4;    // 01 00
  localparam int          ABX_DEST_POS    = 7;
  localparam int          ABX_BIT_LSB     = 7;
  localparam logic [7:0]  ABX_ACC_RST     = 8'h00;
  localparam logic        ABX_DEST_ACC    = 1'b0;

  typedef enum logic [2:0] {
    ABX_NONE, ABX_ADDLIT, ABX_ANDLIT, ABX_ADDREG, ABX_ANDREG, ABX_BITCLR
  } abx_op_e;

  typedef struct packed {
    logic       zero;
    logic       nibble_overflow_bit;
    logic       carry;
  } abx_flags_s;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } abx_regwr_s;
endpackage
`default_nettype wire

// ===== abx_alu.sv
/*
  Combinational adder and AND unit with flag generation.
  Assumes operands are stable within the execute cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module abx_alu
  import abx_pkg::*;
(
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       is_and_i,
  output logic [7:0]      res_o,
  output logic            carry_o,
  output logic            nib_o,
  output logic            zero_o
);
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;

  always_comb begin
    lo_sum  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
    hi_sum  = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, lo_sum[4]};
    nib_o   = lo_sum[4];
    carry_o = hi_sum[4];
    res_o   = is_and_i ? (a_i & b_i) : {hi_sum[3:0], lo_sum[3:0]};
    zero_o  = (res_o == 8'h00);
  end
endmodule
`default_nettype wire

// ===== abx_exec.sv
/*
  Execute stage for five instructions: add/AND literal, add/AND register, bit clear.
  Assumes fetch presents one instruction with a valid strobe per cycle and the
  register file returns the addressed byte combinationally on rd_data_i.
*/
`timescale 1ns/1ps
`default_nettype none
module abx_exec
  import abx_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic                valid_i,
  input  wire logic [13:0]         instr_i,
  input  wire logic [7:0]          rd_data_i,
  input  wire abx_flags_s          flags_i,
  output logic [6:0]               rd_addr_o,
  output abx_regwr_s               wr_o,
  output logic [7:0]               acc_o,
  output abx_flags_s               flags_o,
  output logic                     flags_we_o,
  output logic                     done_o
);
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  abx_op_e    op;
  logic       dest;
  logic [2:0] bsel;
  logic [7:0] lit;

  always_comb begin
    lit  = instr_i[7:0];
    dest = instr_i[ABX_DEST_POS];
    bsel = instr_i[ABX_BIT_LSB +: 3];
    op   = ABX_NONE;
    if (valid_i) begin
      if (instr_i[13:9] == ABX_OP_ADDLIT)      op = ABX_ADDLIT;
      else if (instr_i[13:8] == ABX_OP_ANDLIT) op = ABX_ANDLIT;
      else if (instr_i[13:8] == ABX_OP_ADDREG) op = ABX_ADDREG;
      else if (instr_i[13:8] == ABX_OP_ANDREG) op = ABX_ANDREG;
      else if (instr_i[13:10] == ABX_OP_BITCLR) op = ABX_BITCLR;
    end
  end

  assign rd_addr_o = instr_i[6:0];

  // ------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [7:0] opnd;
  logic [7:0] res;
  logic       c;
  logic       n;
  logic       z;

  assign opnd = (op == ABX_ADDLIT || op == ABX_ANDLIT) ? lit : rd_data_i;

  abx_alu u_alu (
    .a_i      (acc_r),
    .b_i      (opnd),
    .is_and_i (op == ABX_ANDLIT || op == ABX_ANDREG),
    .res_o    (res),
    .carry_o  (c),
    .nib_o    (n),
    .zero_o   (z)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  abx_regwr_s wr_nxt;
  abx_regwr_s wr_r;
  abx_flags_s fl_nxt;
  abx_flags_s fl_r;
  logic       fwe_nxt;
  logic       fwe_r;
  logic       done_nxt;
  logic       done_r;
  logic [7:0] cleared;

  always_comb begin
    acc_nxt  = acc_r;
    wr_nxt   = '0;
    fl_nxt   = fl_r;
    fwe_nxt  = 1'b0;
    done_nxt = (op != ABX_NONE);
    cleared  = rd_data_i;
    cleared[bsel] = 1'b0;
    case (op)
      ABX_ADDLIT: begin
        acc_nxt = res;
        fl_nxt  = '{zero: z, nibble_overflow_bit: n, carry: c};
        fwe_nxt = 1'b1;
      end
      ABX_ANDLIT: begin
        acc_nxt = res;
        fl_nxt  = '{zero: z, nibble_overflow_bit: flags_i.nibble_overflow_bit,
                    carry: flags_i.carry};
        fwe_nxt = 1'b1;
      end
      ABX_ADDREG, ABX_ANDREG: begin
        if (dest == ABX_DEST_ACC) begin
          acc_nxt = res;
        end else begin
          wr_nxt = '{we: 1'b1, addr: rd_addr_o, data: res};
        end
        if (op == ABX_ADDREG) begin
          fl_nxt = '{zero: z, nibble_overflow_bit: n, carry: c};
        end else begin
          fl_nxt = '{zero: z, nibble_overflow_bit: flags_i.nibble_overflow_bit,
                     carry: flags_i.carry};
        end
        fwe_nxt = 1'b1;
      end
      ABX_BITCLR: begin
        wr_nxt = '{we: 1'b1, addr: rd_addr_o, data: cleared};
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_r  <= ABX_ACC_RST;
      wr_r   <= '0;
      fl_r   <= '0;
      fwe_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      wr_r   <= wr_nxt;
      fl_r   <= fl_nxt;
      fwe_r  <= fwe_nxt;
      done_r <= done_nxt;
    end
  end

  assign acc_o      = acc_r;
  assign wr_o       = wr_r;
  assign flags_o    = fl_r;
  assign flags_we_o = fwe_r;
  assign done_o     = done_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_ADDLIT_SUM: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ADDLIT |=> acc_o == 8'($past(acc_r) + $past(lit)) && flags_we_o)
    else $error("add literal result wrong");
  AST_ANDLIT_RES: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ANDLIT |=> acc_o == ($past(acc_r) & $past(lit))
      && flags_o.carry == $past(flags_i.carry))
    else $error("and literal result wrong");
  AST_ADDREG_FLAGS: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ADDREG |=> flags_o.carry == ((9'($past(acc_r)) + 9'($past(rd_data_i))) > 9'd255))
    else $error("add register carry wrong");
  AST_DEST_REG: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (op == ABX_ADDREG || op == ABX_ANDREG) && dest |=> wr_o.we && acc_o == $past(acc_r))
    else $error("register destination wrong");
  AST_DEST_ACC: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (op == ABX_ADDREG || op == ABX_ANDREG) && !dest |=> !wr_o.we)
    else $error("accumulator destination wrote register");
  AST_ANDREG_RES: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ANDREG && dest |=> wr_o.data == ($past(acc_r) & $past(rd_data_i)))
    else $error("and register result wrong");
  AST_BITCLR: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_BITCLR |=> wr_o.we && wr_o.data[$past(bsel)] == 1'b0 && !flags_we_o)
    else $error("bit clear wrong");
  AST_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ANDLIT |=> flags_o.zero == (acc_o == 8'h00))
    else $error("zero flag wrong");

  // ------------------------------------------------------------
  // Checks on flags, routing and pulses
  // ------------------------------------------------------------
  AST_ADDLIT_FLAGS: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ADDLIT |=> flags_o.nibble_overflow_bit
      == ((5'($past(acc_r[3:0])) + 5'($past(lit[3:0]))) > 5'h0f)
      && flags_o.carry == ((9'($past(acc_r)) + 9'($past(lit))) > 9'h0ff))
    else $error("add literal flags wrong");
  AST_ANDLIT_FLAGS: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ANDLIT |=> flags_we_o && !wr_o.we
      && flags_o.nibble_overflow_bit == $past(flags_i.nibble_overflow_bit))
    else $error("and literal flags wrong");
  AST_ADDREG_SUM: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ADDREG && !dest |=> flags_we_o
      && acc_o == 8'($past(acc_r) + $past(rd_data_i)))
    else $error("add register sum wrong");
  AST_ADDREG_NIB: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ADDREG |=> flags_o.nibble_overflow_bit
      == ((5'($past(acc_r[3:0])) + 5'($past(rd_data_i[3:0]))) > 5'h0f))
    else $error("add register nibble carry wrong");
  AST_DEST_ADDR: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (op == ABX_ADDREG || op == ABX_ANDREG) && dest |=> wr_o.addr == $past(instr_i[6:0]))
    else $error("register destination address wrong");
  AST_ANDREG_ACC: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ANDREG && !dest |=> acc_o == ($past(acc_r) & $past(rd_data_i))
      && flags_o.carry == $past(flags_i.carry))
    else $error("and register accumulator result wrong");
  AST_BITCLR_DATA: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_BITCLR |=> wr_o.addr == $past(instr_i[6:0]) && acc_o == $past(acc_r)
      && wr_o.data == ($past(rd_data_i) & ~(8'h01 << $past(bsel))))
    else $error("bit clear data wrong");
  AST_ZERO_ADD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_ADDLIT |=> flags_o.zero == (acc_o == 8'h00))
    else $error("add zero flag wrong");
  AST_DONE_PULSE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op != ABX_NONE |=> done_o)
    else $error("done pulse missing");
  AST_IDLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    op == ABX_NONE |=> !done_o && !wr_o.we && !flags_we_o && acc_o == $past(acc_r))
    else $error("idle cycle changed state");
  COV_ADDLIT: cover property (@(posedge clk_i) op == ABX_ADDLIT && c);
  COV_ADDREG_F: cover property (@(posedge clk_i) op == ABX_ADDREG && dest);
  COV_BITCLR: cover property (@(posedge clk_i) op == ABX_BITCLR);
  COV_ANDLIT_ZERO: cover property (@(posedge clk_i) op == ABX_ANDLIT && z);
  COV_ANDREG_ACC: cover property (@(posedge clk_i) op == ABX_ANDREG && !dest);
endmodule
`default_nettype wire

// ===== abx_regfile_model.sv
/*
  Register file and status model beside the execute block.
  Assumes writes and status updates land on the edge after the pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module abx_regfile_model
  import abx_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [6:0] rd_addr_i,
  input  wire abx_regwr_s wr_i,
  input  wire abx_flags_s flags_i,
  input  wire logic       flags_we_i,
  output logic [7:0]      rd_data_o,
  output abx_flags_s      status_o
);
  logic [7:0] mem [128];
  initial begin
    for (int a = 0; a < 128; a++) mem[a] = 8'(a * 37 + 90);
    status_o = '0;
  end
  assign rd_data_o = mem[rd_addr_i];
  always @(posedge clk_i) begin
    if (wr_i.we) mem[wr_i.addr] <= wr_i.data;
    if (flags_we_i) status_o <= flags_i;
  end
endmodule
`default_nettype wire

// ===== add_and_bitclear_exec_tb_top.sv
/*
  Random and corner tests of abx_exec against a bench reference.
  Assumes abx_regfile_model as register file and status.
*/
`timescale 1ns/1ps
`default_nettype none
module add_and_bitclear_exec_tb_top
  import abx_pkg::*;
;
  logic        clk_i = 0, resetn_i = 0, valid_i = 0, fwe, done;
  logic [13:0] instr_i = '0;
  logic [7:0]  rd, acc, acc_e = '0, mem_e [128];
  logic [6:0]  ra;
  abx_regwr_s  wr;
  abx_flags_s  fl, st, fl_e = '0;
  int          mismatches = 0, comparisons = 0;
  always #10 clk_i = ~clk_i;
  abx_exec dut (.clk_i(clk_i), .resetn_i(resetn_i), .valid_i(valid_i), .instr_i(instr_i),
    .rd_data_i(rd), .flags_i(st), .rd_addr_o(ra), .wr_o(wr), .acc_o(acc), .flags_o(fl),
    .flags_we_o(fwe), .done_o(done));
  abx_regfile_model mdl (.clk_i(clk_i), .rd_addr_i(ra), .wr_i(wr), .flags_i(fl),
    .flags_we_i(fwe), .rd_data_o(rd), .status_o(st));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [9:0] exp_add(input logic [7:0] a, input logic [7:0] b);
    logic [4:0] lo;
    lo = 5'(a[3:0]) + 5'(b[3:0]);
    return {lo[4], 9'(a) + 9'(b)};
  endfunction
  task automatic run(input logic [13:0] i);
    logic [7:0] f, k, r;
    logic [9:0] s;
    logic       ad, an, bc, wb;
    f = mem_e[i[6:0]];
    ad = i[13:9] == ABX_OP_ADDLIT || i[13:8] == ABX_OP_ADDREG;
    an = i[13:8] == ABX_OP_ANDLIT || i[13:8] == ABX_OP_ANDREG;
    bc = i[13:10] == ABX_OP_BITCLR;
    k = (i[13:12] == 2'b00) ? f : i[7:0];
    s = exp_add(acc_e, k);
    r = bc ? (f & ~(8'h01 << i[9:7])) : an ? (acc_e & k) : s[7:0];
    wb = bc | ((ad | an) & i[13:12] == 2'b00 & i[7]);
    if (ad | an) fl_e = {r == 8'h00, ad ? s[9] : fl_e[1], ad ? s[8] : fl_e[0]};
    if (wb) mem_e[i[6:0]] = r;
    else if (ad | an) acc_e = r;
    @(posedge clk_i);
    #1;
    valid_i = 1;
    instr_i = i;
    @(posedge clk_i);
    chk("rd_addr", 16'(i[6:0]), 16'(ra));
    #1;
    valid_i = 0;
    instr_i = 14'($urandom);
    chk("done", 16'(ad | an | bc), 16'(done));
    chk("flags_we", 16'(ad | an), 16'(fwe));
    if (ad | an) chk("flags", 16'(fl_e), 16'(fl));
    chk("we", 16'(wb), 16'(wr.we));
    if (wb) chk("wr", 16'({1'b1, i[6:0], r}), 16'(wr));
    chk("acc", 16'(acc_e), 16'(acc));
  endtask
  initial begin
    logic [13:0] x;
    void'($urandom(32'hfb6d));
    for (int a = 0; a < 128; a++) mem_e[a] = 8'(a * 37 + 90);
    repeat (8) @(posedge clk_i);
    #1;
    resetn_i = 1;
    run(14'h3E10);
    run(14'h3E15);
    run(14'h3FDB);
    run(14'h3EA3);
    run(14'h395F);
    run(14'h3900);
    run(14'h0705);
    run(14'h07FF);
    run(14'h0505);
    run(14'h05FF);
    run(14'h13FF);
    run(14'h1000);
    run(14'h3A55);
    run(14'h0000);
    @(posedge clk_i);
    #1;
    resetn_i = 0;
    @(posedge clk_i);
    #1;
    chk("rst_acc", 16'(ABX_ACC_RST), 16'(acc));
    chk("rst_we", 16'(0), 16'(wr.we));
    chk("rst_done", 16'(0), 16'(done));
    resetn_i = 1;
    acc_e = ABX_ACC_RST;
    run(14'h3E15);
    repeat (300) begin
      x = 14'($urandom);
      case ($urandom % 6)
        0: x[13:9] = ABX_OP_ADDLIT;
        1: x[13:8] = ABX_OP_ANDLIT;
        2: x[13:8] = ABX_OP_ADDREG;
        3: x[13:8] = ABX_OP_ANDREG;
        4: x[13:10] = ABX_OP_BITCLR;
        default: ;
      endcase
      run(x);
    end
    finish_test();
  end
  initial begin
    #(20 * 5000);
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
